// ==== core/pbs_regs.svh ====
// Register map, field positions and frame constants of the basic status block
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH

// ============================================================
// Register indices on the management interface
`define PBS_REG_CTRL        5'h00
`define PBS_REG_STATUS      5'h01

// ============================================================
// Status register fixed content and reset value
`define PBS_STATUS_FIXED    16'h7849
`define PBS_STATUS_RESET    16'h7849

// Status register bit positions
`define PBS_BIT_FOUR_PAIR   15
`define PBS_BIT_FAST_FD     14
`define PBS_BIT_FAST_HD     13
`define PBS_BIT_TEN_FD      12
`define PBS_BIT_TEN_HD      11
`define PBS_RSVD_HI         10
`define PBS_RSVD_LO         7
`define PBS_BIT_NO_PREAMBLE 6
`define PBS_BIT_AN_DONE     5
`define PBS_BIT_REM_FAULT   4
`define PBS_BIT_AN_CAPABLE  3
`define PBS_BIT_LINK_UP     2
`define PBS_BIT_JABBER      1
`define PBS_BIT_EXT_REGS    0

// Control register field
`define PBS_BIT_AN_RESTART  9

// ============================================================
// Management frame layout
`define PBS_OP_READ         2'h2
`define PBS_OP_WRITE        2'h1
`define PBS_HDR_LAST        4'hb
`define PBS_TA_LAST         4'h1
`define PBS_DATA_LAST       4'hf
`define PBS_CNT_ZERO        4'h0
`define PBS_CNT_ONE         4'h1

// Idle levels of the filtered pins, clock low and data high
`define PBS_PIN_IDLE        2'h1

`endif

// ==== core/pbs_pkg.sv ====
// Types shared by the basic status block
package pbs_pkg;

	// Management frame sequencer states
	typedef enum logic [1:0]
	{
		PBS_IDLE,
		PBS_HDR,
		PBS_TA,
		PBS_DATA
	} pbs_state_t;

endpackage

// ==== core/pbs_status.sv ====
// Port basic status register with its management serial access
`timescale 1ns/1ps
`include "pbs_regs.svh"

// Overview of operation
// - Bit 15 always reads zero since four-pair operation is not supported.
// - Bits 14 and 13 always read one for fast twisted-pair full and half duplex.
// - Bits 12 and 11 always read one for 10 Mb/s full and half duplex.
// - Bits 10 down to 7 are reserved and always read zero.
// - Bit 6 reads one because frames without a preamble are accepted.
// - Bit 5 is set once autonegotiation finishes, marking its results valid.
// - Bit 5 is cleared when autonegotiation is started or restarted in a cycle where it does not also finish.
// - After reset bit 5 and bit 4 both read zero.
// - Bit 4 latches a detected remote fault until a status read clears it.
// - Bit 3 always reads one since autonegotiation is supported.
// - Bit 2 shows link up, latches low on failure and recovers on a read.
// - Bit 1 latches jabber and clears only after a read with jabber gone.
// - Bit 0 always reads one as the extended register set exists.
// - Writing the restart control bit clears bit 5 unless autonegotiation finishes in that cycle; it self-clears at restart.
module pbs_status
	import pbs_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        MDC,
	input  wire logic        MDIO_I,
	output logic             MDIO_O,
	output logic             MDIO_OE,
	input  wire logic [4:0]  PHY_ADDR,
	input  wire logic        AN_STARTED,
	input  wire logic        AN_DONE,
	input  wire logic        REMOTE_FAULT,
	input  wire logic        LINK_OK,
	input  wire logic        JABBER,
	output logic             AUTONEG_RESTART_REQUEST,
	output logic [15:0]      STATUS_WORD
);

	// ============================================================
	// Pin synchronisers, bit 1 is the clock pin, bit 0 the data pin
	logic [1:0]  sync1_q;
	logic [1:0]  sync2_q;
	logic [1:0]  sync3_q;
	logic [1:0]  pin_q;
	logic        mdc_rise;
	logic        mdio_bit;
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sync1_q <= `PBS_PIN_IDLE;
			sync2_q <= `PBS_PIN_IDLE;
			sync3_q <= `PBS_PIN_IDLE;
			pin_q   <= `PBS_PIN_IDLE;
		end
		else
		begin
			sync1_q <= {MDC, MDIO_I};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 2; i++)
			begin
				if (sync2_q[i] == sync3_q[i])
					pin_q[i] <= sync3_q[i];
			end
		end
	end

	// Accepted clock edge when the filtered level turns high
	assign mdc_rise = (sync2_q[1] == sync3_q[1]) && sync3_q[1] && !pin_q[1];
	assign mdio_bit = pin_q[0];

	// ============================================================
	// Strap capture
	logic [4:0]  addr_q;
	always_ff @(posedge CLK)
	begin
		if (RST)
			addr_q <= PHY_ADDR;
	end

	// ============================================================
	// Status word composition
	logic        an_q;
	logic        rf_q;
	logic        link_q;
	logic        jab_q;
	logic        restart_q;
	logic [15:0] status_now;
	logic [15:0] ctrl_now;
	always_comb
	begin
		status_now = `PBS_STATUS_FIXED;
		status_now[`PBS_BIT_FOUR_PAIR] = 1'b0;
		status_now[`PBS_BIT_FAST_FD] = 1'b1;
		status_now[`PBS_BIT_FAST_HD] = 1'b1;
		status_now[`PBS_BIT_TEN_FD] = 1'b1;
		status_now[`PBS_BIT_TEN_HD] = 1'b1;
		status_now[`PBS_RSVD_HI:`PBS_RSVD_LO] = 4'h0;
		status_now[`PBS_BIT_NO_PREAMBLE] = 1'b1;
		status_now[`PBS_BIT_AN_DONE] = an_q;
		status_now[`PBS_BIT_REM_FAULT] = rf_q;
		status_now[`PBS_BIT_AN_CAPABLE] = 1'b1;
		status_now[`PBS_BIT_LINK_UP] = link_q;
		status_now[`PBS_BIT_JABBER] = jab_q;
		status_now[`PBS_BIT_EXT_REGS] = 1'b1;
		ctrl_now = 16'h0000;
		ctrl_now[`PBS_BIT_AN_RESTART] = restart_q;
	end

	// ============================================================
	// Management frame sequencer
	pbs_state_t  state_q;
	logic        prev_q;
	logic [3:0]  cnt_q;
	logic [11:0] hdr_q;
	logic [11:0] hdr_full;
	logic [4:0]  reg_q;
	logic        rd_q;
	logic        hit_q;
	logic [15:0] sh_q;
	logic [15:0] wr_word;
	logic        out_q;
	logic        oe_q;
	logic        read_done_q;
	logic        wr_restart_q;
	logic        hdr_end;
	logic        hdr_hit;
	logic        snap_now;
	always_comb
	begin
		hdr_full = {hdr_q[10:0], mdio_bit};
		wr_word  = {sh_q[14:0], mdio_bit};
		hdr_end  = mdc_rise && (state_q == PBS_HDR) &&
			(cnt_q == `PBS_HDR_LAST);
		hdr_hit  = (hdr_full[9:5] == addr_q) &&
			((hdr_full[11:10] == `PBS_OP_READ) ||
			(hdr_full[11:10] == `PBS_OP_WRITE));
		snap_now = hdr_end && hdr_hit &&
			(hdr_full[11:10] == `PBS_OP_READ) &&
			(hdr_full[4:0] == `PBS_REG_STATUS);
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_q      <= PBS_IDLE;
			prev_q       <= 1'b1;
			cnt_q        <= `PBS_CNT_ZERO;
			hdr_q        <= 12'h000;
			reg_q        <= 5'h00;
			rd_q         <= 1'b0;
			hit_q        <= 1'b0;
			sh_q         <= 16'h0000;
			out_q        <= 1'b1;
			oe_q         <= 1'b0;
			read_done_q  <= 1'b0;
			wr_restart_q <= 1'b0;
		end
		else
		begin
			read_done_q  <= 1'b0;
			wr_restart_q <= 1'b0;
			if (mdc_rise)
			begin
				case (state_q)
					PBS_IDLE:
					begin
						// Start pattern 0 then 1, preamble optional
						prev_q <= mdio_bit;
						if (!prev_q && mdio_bit)
						begin
							state_q <= PBS_HDR;
							cnt_q   <= `PBS_CNT_ZERO;
						end
					end
					PBS_HDR:
					begin
						hdr_q <= hdr_full;
						cnt_q <= cnt_q + `PBS_CNT_ONE;
						if (hdr_end)
						begin
							state_q <= PBS_TA;
							cnt_q   <= `PBS_CNT_ZERO;
							reg_q   <= hdr_full[4:0];
							rd_q    <= hdr_full[11:10] == `PBS_OP_READ;
							hit_q   <= hdr_hit;
							if (hdr_full[4:0] == `PBS_REG_STATUS)
								sh_q <= status_now;
							else if (hdr_full[4:0] == `PBS_REG_CTRL)
								sh_q <= ctrl_now;
							else
								sh_q <= 16'h0000;
						end
					end
					PBS_TA:
					begin
						cnt_q <= cnt_q + `PBS_CNT_ONE;
						if (rd_q && hit_q)
						begin
							oe_q <= 1'b1;
							out_q <= 1'b0;
						end
						if (cnt_q == `PBS_TA_LAST)
						begin
							state_q <= PBS_DATA;
							cnt_q   <= `PBS_CNT_ZERO;
							if (rd_q && hit_q)
							begin
								out_q <= sh_q[15];
								sh_q  <= {sh_q[14:0], 1'b0};
							end
						end
					end
					PBS_DATA:
					begin
						cnt_q <= cnt_q + `PBS_CNT_ONE;
						if (rd_q)
						begin
							out_q <= sh_q[15];
							sh_q  <= {sh_q[14:0], 1'b0};
						end
						else
							sh_q <= wr_word;
						if (cnt_q == `PBS_DATA_LAST)
						begin
							state_q <= PBS_IDLE;
							prev_q  <= 1'b1;
							oe_q    <= 1'b0;
							out_q   <= 1'b1;
							// Clears follow the end of the read
							read_done_q <= rd_q && hit_q &&
								(reg_q == `PBS_REG_STATUS);
							wr_restart_q <= !rd_q && hit_q &&
								(reg_q == `PBS_REG_CTRL) &&
								wr_word[`PBS_BIT_AN_RESTART];
						end
					end
					default:
					begin
						state_q <= PBS_IDLE;
						oe_q    <= 1'b0;
					end
				endcase
			end
		end
	end

	// ============================================================
	// Events seen while a status read is in flight
	logic        rf_seen_q;
	logic        lf_seen_q;
	logic        jb_seen_q;
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rf_seen_q <= 1'b0;
			lf_seen_q <= 1'b0;
			jb_seen_q <= 1'b0;
		end
		else if (snap_now)
		begin
			rf_seen_q <= REMOTE_FAULT;
			lf_seen_q <= !LINK_OK;
			jb_seen_q <= JABBER;
		end
		else
		begin
			rf_seen_q <= rf_seen_q | REMOTE_FAULT;
			lf_seen_q <= lf_seen_q | !LINK_OK;
			jb_seen_q <= jb_seen_q | JABBER;
		end
	end

	// ============================================================
	// Latched status bits
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rf_q   <= 1'b0;
			link_q <= 1'b0;
			jab_q  <= 1'b0;
		end
		else if (read_done_q)
		begin
			rf_q   <= rf_seen_q | REMOTE_FAULT;
			link_q <= !lf_seen_q & LINK_OK;
			jab_q  <= jb_seen_q | JABBER;
		end
		else
		begin
			rf_q   <= rf_q | REMOTE_FAULT;
			link_q <= link_q & LINK_OK;
			jab_q  <= jab_q | JABBER;
		end
	end

	// ============================================================
	// Autonegotiation complete and restart request
	always_ff @(posedge CLK)
	begin
		if (RST)
			an_q <= 1'b0;
		else if (AN_DONE)
			an_q <= 1'b1;
		else if (AN_STARTED || wr_restart_q)
			an_q <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			restart_q <= 1'b0;
		else if (wr_restart_q)
			restart_q <= 1'b1;
		else if (AN_STARTED)
			restart_q <= 1'b0;
	end

	// ============================================================
	// Outputs
	logic [15:0] stat_q;
	always_ff @(posedge CLK)
	begin
		if (RST)
			stat_q <= `PBS_STATUS_RESET;
		else
			stat_q <= status_now;
	end

	assign MDIO_O                  = out_q;
	assign MDIO_OE                 = oe_q;
	assign AUTONEG_RESTART_REQUEST = restart_q;
	assign STATUS_WORD             = stat_q;
endmodule // pbs_status

// ==== dv/pbs_status_checker.sv ====
// Port-level assertions for the basic status block
`timescale 1ns/1ps
module pbs_status_checker
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        MDIO_OE,
	input wire logic        AN_STARTED,
	input wire logic        AN_DONE,
	input wire logic        REMOTE_FAULT,
	input wire logic        LINK_OK,
	input wire logic        JABBER,
	input wire logic        AUTONEG_RESTART_REQUEST,
	input wire logic [15:0] STATUS_WORD
);
	logic [3:0] oe_q;

	// ============================================================
	// Recent end of a driven read
	always_ff @(posedge CLK)
		oe_q <= RST ? 4'h0 : {oe_q[2:0], MDIO_OE};

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	property p_four_pair; STATUS_WORD[15] == 1'b0; endproperty
	a_four_pair: assert property (p_four_pair)
		else $error("four pair bit set");
	property p_speeds; STATUS_WORD[14:11] == 4'hf; endproperty
	a_speeds: assert property (p_speeds)
		else $error("speed bits wrong");
	property p_rsvd; STATUS_WORD[10:7] == 4'h0; endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits set");
	property p_fixed; {STATUS_WORD[6], STATUS_WORD[3], STATUS_WORD[0]} == 3'h7;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed ones wrong");
	property p_rst; $fell(RST) |-> STATUS_WORD == 16'h7849; endproperty
	a_rst: assert property (p_rst)
		else $error("reset value wrong");
	property p_done; AN_DONE |-> ##2 STATUS_WORD[5]; endproperty
	a_done: assert property (p_done)
		else $error("done not set");
	property p_start; AN_STARTED && !AN_DONE |-> ##2 !STATUS_WORD[5]; endproperty
	a_start: assert property (p_start)
		else $error("done not cleared");
	property p_rf; REMOTE_FAULT |-> ##2 STATUS_WORD[4]; endproperty
	a_rf: assert property (p_rf)
		else $error("fault not latched");
	property p_rfclr; $fell(STATUS_WORD[4]) |-> |oe_q; endproperty
	a_rfclr: assert property (p_rfclr)
		else $error("fault cleared without read");
	property p_lnk; !LINK_OK |-> ##2 !STATUS_WORD[2]; endproperty
	a_lnk: assert property (p_lnk)
		else $error("link not latched low");
	property p_lnkup; $rose(STATUS_WORD[2]) |-> |oe_q; endproperty
	a_lnkup: assert property (p_lnkup)
		else $error("link rose without read");
	property p_jab; JABBER |-> ##2 STATUS_WORD[1]; endproperty
	a_jab: assert property (p_jab)
		else $error("jabber not latched");
	property p_jabclr; $fell(STATUS_WORD[1]) |-> |oe_q && !$past(JABBER, 2);
	endproperty
	a_jabclr: assert property (p_jabclr)
		else $error("jabber cleared early");
	property p_req; AN_STARTED |=> !AUTONEG_RESTART_REQUEST; endproperty
	a_req: assert property (p_req)
		else $error("restart request kept");
endmodule // pbs_status_checker

bind pbs_status pbs_status_checker i_chk
(
	.CLK(CLK), .RST(RST), .MDIO_OE(MDIO_OE), .AN_STARTED(AN_STARTED),
	.AN_DONE(AN_DONE), .REMOTE_FAULT(REMOTE_FAULT), .LINK_OK(LINK_OK),
	.JABBER(JABBER), .AUTONEG_RESTART_REQUEST(AUTONEG_RESTART_REQUEST),
	.STATUS_WORD(STATUS_WORD)
);

// ==== dv/pbs_sta.sv ====
// Station manager model driving management frames
`timescale 1ns/1ps
module pbs_sta
(
	output logic      mdc,
	output logic      mdo,
	output logic      mdo_en,
	input  wire logic mdio
);
	initial
	begin
		mdc = 1'b0;
		mdo = 1'b1;
		mdo_en = 1'b0;
	end

	// One bit, clock idles low between frames
	task automatic bt(input logic v, output logic s);
		mdo = v;
		#62.5 mdc = 1'b1;
		s = mdio;
		#62.5 mdc = 1'b0;
	endtask

	task automatic frame(input logic [4:0] ad, input logic [1:0] op,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [15:0] h;
		logic [17:0] t;
		logic        s;
		h = {4'hd, op, ad, ra};
		t = {2'h2, wd};
		rd = 16'h0000;
		mdo_en = 1'b1;
		for (int i = 15; i >= 0; i--)
			bt(h[i], s);
		mdo_en = (op == 2'h1);
		for (int i = 17; i >= 0; i--)
		begin
			bt(t[i], s);
			rd = {rd[14:0], s};
		end
		mdo_en = 1'b0;
		mdo = 1'b1;
	endtask
endmodule // pbs_sta

// ==== dv/tb_pbs_status.sv ====
// Self-checking bench for the basic status block
`timescale 1ns/1ps
module tb_pbs_status;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  ev = 5'h00;
	logic [15:0] rd;
	logic [15:0] sw;
	logic        mdc, sdo, sen, mo, moe, req;
	wire         mdio_w;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	always #5 clk = ~clk;
	// Pulled-up data line
	assign mdio_w = moe ? mo : (sen ? sdo : 1'b1);

	pbs_sta i_sta (.mdc(mdc), .mdo(sdo), .mdo_en(sen), .mdio(mdio_w));
	pbs_status i_dut
	(
		.CLK(clk), .RST(rst), .MDC(mdc), .MDIO_I(mdio_w), .MDIO_O(mo),
		.MDIO_OE(moe), .PHY_ADDR(5'h03), .AN_STARTED(ev[4]),
		.AN_DONE(ev[3]), .REMOTE_FAULT(ev[2]), .LINK_OK(ev[1]),
		.JABBER(ev[0]), .AUTONEG_RESTART_REQUEST(req), .STATUS_WORD(sw)
	);

	task complete_run;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Levels stay, event pulses last one cycle
	task put(input logic [4:0] v);
		@(negedge clk) ev = v;
		@(negedge clk) ev = v & 5'h03;
		repeat (3) @(negedge clk);
	endtask

	task mf(input logic [4:0] ad, input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd);
		i_sta.frame(ad, op, ra, wd, rd);
		repeat (8) @(negedge clk);
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			complete_run;
		end
	end

	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(sw, 16'h7849);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(rd, 16'h7849);
		put(5'h02);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(rd, 16'h7849);
		chk(sw, 16'h784d);
		put(5'h00);
		put(5'h02);
		chk(sw, 16'h7849);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(sw, 16'h784d);
		put(5'h0a);
		chk(sw, 16'h786d);
		put(5'h12);
		chk(sw, 16'h784d);
		put(5'h0a);
		put(5'h06);
		chk(sw, 16'h787d);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(rd, 16'h787d);
		chk(sw, 16'h786d);
		put(5'h03);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(sw, 16'h786f);
		put(5'h02);
		chk(sw, 16'h786f);
		mf(5'h03, 2'h2, 5'h01, 16'h0000);
		chk(sw, 16'h786d);
		mf(5'h03, 2'h1, 5'h00, 16'h0200);
		chk({15'h0000, req}, 16'h0001);
		chk(sw, 16'h784d);
		mf(5'h03, 2'h2, 5'h00, 16'h0000);
		chk(rd, 16'h0200);
		put(5'h12);
		chk({15'h0000, req}, 16'h0000);
		fork
			mf(5'h03, 2'h2, 5'h01, 16'h0000);
			begin
				repeat (300) @(negedge clk);
				ev = 5'h06;
				@(negedge clk) ev = 5'h02;
			end
		join
		chk(rd, 16'h784d);
		chk(sw, 16'h785d);
		mf(5'h03, 2'h3, 5'h01, 16'h0000);
		chk(rd, 16'hffff);
		chk(sw, 16'h785d);
		mf(5'h04, 2'h2, 5'h01, 16'h0000);
		chk(rd, 16'hffff);
		mf(5'h03, 2'h2, 5'h05, 16'h0000);
		chk(rd, 16'h0000);
		mf(5'h03, 2'h1, 5'h01, 16'h0000);
		chk(sw, 16'h785d);
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(sw, 16'h7849);
		complete_run;
	end
endmodule // tb_pbs_status
